/* File: shpg_bank_if.sv */
// Purpose: Carries one register bank between decoder and bank storage
// Assumes: Strobes are one-cycle pulses from the bus decoder
// Notes:   W is the number of pins the bank really serves

`timescale 1ns/1ns

interface shpg_bank_if #(
  parameter int unsigned W = 16
);
  logic          wr_enable;
  logic          wr_direction;
  logic          wr_value;
  logic [1:0]    be;
  logic [15:0]   wdata;
  logic [W-1:0]  enable;
  logic [W-1:0]  direction;
  logic [W-1:0]  value;

  modport bank (
    input  wr_enable,
    input  wr_direction,
    input  wr_value,
    input  be,
    input  wdata,
    output enable,
    output direction,
    output value
  );

  modport ctrl (
    output wr_enable,
    output wr_direction,
    output wr_value,
    output be,
    output wdata,
    input  enable,
    input  direction,
    input  value
  );
endinterface

/* File: shpg_pin_bank.sv */
// Purpose: Enable, direction and output-value storage for one pin bank
// Assumes: Byte lane 0 covers bits 7-0, lane 1 bits 15-8
// Notes:   Bits above W are not stored and read as zero upstream

`timescale 1ns/1ns

module shpg_pin_bank #(
  parameter int unsigned W = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  shpg_bank_if.bank b
);
  import shpg_pkg::*;

  logic [W-1:0] enable;
  logic [W-1:0] direction;
  logic [W-1:0] value;
  logic [W-1:0] next_enable;
  logic [W-1:0] next_direction;
  logic [W-1:0] next_value;
  logic [W-1:0] mask;

  always_comb begin
    next_enable    = enable;
    next_direction = direction;
    next_value     = value;
    for (int k = 0; k < W; k++) begin
      mask[k] = b.be[k / 8];
    end
    if (b.wr_enable) begin
      next_enable = (enable & ~mask) | (b.wdata[W-1:0] & mask);
    end
    if (b.wr_direction) begin
      next_direction = (direction & ~mask) | (b.wdata[W-1:0] & mask);
    end
    if (b.wr_value) begin
      // Stored even while an input, so it is ready when turned to output
      next_value = (value & ~mask) | (b.wdata[W-1:0] & mask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable    <= RST_ENABLE[W-1:0];
      direction <= RST_DIRECTION[W-1:0];
      value     <= RST_VALUE[W-1:0];
    end else begin
      enable    <= next_enable;
      direction <= next_direction;
      value     <= next_value;
    end
  end

  assign b.enable    = enable;
  assign b.direction = direction;
  assign b.value     = value;

endmodule

/* File: shpg_pin_model.sv */
// Purpose: Board side of the shared pins
// Assumes: No pulls; outside world sets undriven levels
// Notes:   Contention is not modelled
`timescale 1ns/1ns
module shpg_pin_model import shpg_pkg::*; (
  input  wire logic [PIN_COUNT-1:0] drv_i,
  input  wire logic [PIN_COUNT-1:0] drv_oe_i,
  input  wire logic [PIN_COUNT-1:0] ext_i,
  output logic      [PIN_COUNT-1:0] level_o
);
  // Driven pins follow the port, the rest the outside level
  assign level_o = (drv_oe_i & drv_i) | (~drv_oe_i & ext_i);
endmodule

/* File: shpg_pkg.sv */
// Purpose: Shared constants for the shared-pin general-purpose port
// Assumes: Word-aligned classic Wishbone, 32-bit data, 16-bit registers
// Notes:   Byte address of a register is four times its index

package shpg_pkg;

  localparam int unsigned PIN_COUNT  = 46;
  localparam int unsigned BANK_W     = 16;
  localparam int unsigned NUM_BANKS  = 3;
  localparam int unsigned PAD_W      = BANK_W * NUM_BANKS;
  localparam int unsigned WB_ADR_W   = 20;
  localparam int unsigned WB_IDX_W   = 18;
  localparam int unsigned WB_DAT_W   = 32;
  localparam int unsigned WB_SEL_W   = 4;

  // Register indices; bank n occupies three consecutive indices
  localparam logic [17:0] IDX_ENABLE_LOW     = 18'h04400;
  localparam logic [17:0] IDX_DIRECTION_LOW  = 18'h04401;
  localparam logic [17:0] IDX_VALUE_LOW      = 18'h04402;
  localparam logic [17:0] IDX_BANK_STRIDE    = 18'h00003;
  localparam logic [17:0] IDX_BUS_SELECT     = 18'h04410;

  // Field positions
  localparam int unsigned MUX_MODE_BIT       = 0;

  // Reset values
  localparam logic [15:0] RST_ENABLE         = 16'h0000;
  localparam logic [15:0] RST_DIRECTION      = 16'h0000;
  localparam logic [15:0] RST_VALUE          = 16'h0000;
  localparam logic        RST_MUX_MODE       = 1'b0;

  // Pin groups in general-purpose numbering
  localparam int unsigned ADDR_PIN_LO        = 0;
  localparam int unsigned DATA_PIN_LO        = 4;
  localparam int unsigned CTRL_PIN_LO        = 20;
  localparam int unsigned HOST_DATA_PIN_LO   = 36;
  localparam int unsigned HOST_CTRL0_PIN     = 44;
  localparam int unsigned HOST_CTRL1_PIN     = 45;

endpackage

/* File: shpg_port.sv */
// Purpose: General-purpose control of 46 pins shared with memory and host ports
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset
// Notes:   Mux mode set hands every shared pin to its interface function
//
// How it works
// - Pins act as general-purpose only while mux mode bit is zero.
// - Mux mode one routes pins to memory and host interface functions.
// - Mux mode wins over any enable bit.
// - Address pins are bits 3-0, upper data pins bits 19-4.
// - Control pins C0..C15 are bits 20..35 ascending.
// - Host data bits 43-36, host control 0 bit 44, control 1 bit 45.
// - Three banks hold enable, direction and data, one bit per pin.
// - Enable gates the driver; direction chooses driven or sampled data.
// - Data bits hold the driven value or the sampled pin level.
// - Enable and direction both one drives the data bit onto the pin.
// - Enable and direction both zero makes data reads return the pin.
// - Enable low register at index 4400, sixteen bits, resets to zero.
// - Enable bit zero never drives the pin while mux mode is zero.
// - Direction low register has sixteen bits resetting to zero, inputs.
// - Direction low register sits at index 4401.
// - After reset data bits read back the live pin level.

`timescale 1ns/1ns

module shpg_port (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [shpg_pkg::WB_ADR_W-1:0]   wb_adr_i,
  input  wire logic [shpg_pkg::WB_SEL_W-1:0]   wb_sel_i,
  input  wire logic [shpg_pkg::WB_DAT_W-1:0]   wb_dat_i,
  output logic      [shpg_pkg::WB_DAT_W-1:0]   wb_dat_o,
  output logic                                 wb_ack_o,
  input  wire logic [shpg_pkg::PIN_COUNT-1:0]  pin_i,
  output logic      [shpg_pkg::PIN_COUNT-1:0]  pin_o,
  output logic      [shpg_pkg::PIN_COUNT-1:0]  pin_oe_o,
  input  wire logic [shpg_pkg::PIN_COUNT-1:0]  func_out_i,
  input  wire logic [shpg_pkg::PIN_COUNT-1:0]  func_oe_i,
  output logic      [shpg_pkg::PIN_COUNT-1:0]  func_in_o,
  output logic                                 mux_mode_o
);
  import shpg_pkg::*;

  logic [WB_IDX_W-1:0]  idx;
  logic                 req;
  logic                 wr_req;

  logic                 ack;
  logic                 next_ack;
  logic [WB_DAT_W-1:0]  rdata;
  logic [WB_DAT_W-1:0]  next_rdata;

  logic                 mux_mode;
  logic                 next_mux_mode;

  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] next_pin_meta;
  logic [PIN_COUNT-1:0] next_pin_sync;

  logic [PIN_COUNT-1:0] pin_out;
  logic [PIN_COUNT-1:0] pin_oe;
  logic [PIN_COUNT-1:0] next_pin_out;
  logic [PIN_COUNT-1:0] next_pin_oe;

  logic [PIN_COUNT-1:0] enable_all;
  logic [PIN_COUNT-1:0] direction_all;
  logic [PIN_COUNT-1:0] value_all;
  logic [PAD_W-1:0]     enable_pad;
  logic [PAD_W-1:0]     direction_pad;
  logic [PAD_W-1:0]     readback_pad;

  logic [NUM_BANKS-1:0] hit_enable;
  logic [NUM_BANKS-1:0] hit_direction;
  logic [NUM_BANKS-1:0] hit_value;
  logic                 hit_select;

  assign idx    = wb_adr_i[WB_ADR_W-1:2];
  // New request only while no answer is standing, so each access acts once
  assign req    = wb_cyc_i & wb_stb_i & ~ack;
  assign wr_req = req & wb_we_i;

  // Address decode for all banks
  always_comb begin
    for (int n = 0; n < NUM_BANKS; n++) begin
      hit_enable[n]    = (idx == IDX_ENABLE_LOW + IDX_BANK_STRIDE * n[17:0]);
      hit_direction[n] = (idx == IDX_DIRECTION_LOW + IDX_BANK_STRIDE * n[17:0]);
      hit_value[n]     = (idx == IDX_VALUE_LOW + IDX_BANK_STRIDE * n[17:0]);
    end
    hit_select = (idx == IDX_BUS_SELECT);
  end

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : gen_bank
      localparam int unsigned BW = (g == NUM_BANKS - 1) ? PIN_COUNT - BANK_W * g : BANK_W;
      shpg_bank_if #(.W(BW)) bif ();

      assign bif.wr_enable    = wr_req & hit_enable[g];
      assign bif.wr_direction = wr_req & hit_direction[g];
      assign bif.wr_value     = wr_req & hit_value[g];
      assign bif.be           = wb_sel_i[1:0];
      assign bif.wdata        = wb_dat_i[15:0];

      assign enable_all[BANK_W*g +: BW]    = bif.enable;
      assign direction_all[BANK_W*g +: BW] = bif.direction;
      assign value_all[BANK_W*g +: BW]     = bif.value;

      shpg_pin_bank #(.W(BW)) u_bank (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .b     (bif)
      );
    end
  endgenerate

  // Readback: stored value for outputs, synchronised pin level for inputs
  always_comb begin
    enable_pad    = '0;
    direction_pad = '0;
    readback_pad  = '0;
    enable_pad[PIN_COUNT-1:0]    = enable_all;
    direction_pad[PIN_COUNT-1:0] = direction_all;
    for (int i = 0; i < PIN_COUNT; i++) begin
      readback_pad[i] = direction_all[i] ? value_all[i] : pin_sync[i];
    end
  end

  // Bus answer and register reads
  always_comb begin
    next_ack      = req;
    next_rdata    = rdata;
    next_mux_mode = mux_mode;
    if (req) begin
      next_rdata = '0;
      for (int n = 0; n < NUM_BANKS; n++) begin
        if (hit_enable[n]) begin
          next_rdata[15:0] = enable_pad[BANK_W*n +: BANK_W];
        end
        if (hit_direction[n]) begin
          next_rdata[15:0] = direction_pad[BANK_W*n +: BANK_W];
        end
        if (hit_value[n]) begin
          next_rdata[15:0] = readback_pad[BANK_W*n +: BANK_W];
        end
      end
      if (hit_select) begin
        next_rdata[MUX_MODE_BIT] = mux_mode;
      end
      if (wr_req && hit_select && wb_sel_i[0]) begin
        next_mux_mode = wb_dat_i[MUX_MODE_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack      <= 1'b0;
      rdata    <= '0;
      mux_mode <= RST_MUX_MODE;
    end else begin
      ack      <= next_ack;
      rdata    <= next_rdata;
      mux_mode <= next_mux_mode;
    end
  end

  // Two-stage synchroniser; first stage feeds only the second
  always_comb begin
    next_pin_meta = pin_i;
    next_pin_sync = pin_meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
    end
  end

  // Pin ownership; numbering already matches the pin order of each group
  // An enabled pin with direction low still drives its stored bit
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (mux_mode) begin
        next_pin_out[i] = func_out_i[i];
        next_pin_oe[i]  = func_oe_i[i];
      end else begin
        next_pin_out[i] = value_all[i];
        next_pin_oe[i]  = enable_all[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  assign wb_ack_o   = ack;
  assign wb_dat_o   = rdata;
  assign pin_o      = pin_out;
  assign pin_oe_o   = pin_oe;
  assign func_in_o  = pin_sync;
  assign mux_mode_o = mux_mode;

endmodule

/* File: shpg_port_chk.sv */
// Purpose: Port-level assertions for shpg_port
// Assumes: Single clock, reset synchronous active high
// Notes:   Bound into every shpg_port instance
`timescale 1ns/1ns
module shpg_port_chk import shpg_pkg::*; (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [WB_ADR_W-1:0]   wb_adr_i,
  input wire logic [WB_SEL_W-1:0]   wb_sel_i,
  input wire logic [WB_DAT_W-1:0]   wb_dat_i,
  input wire logic [WB_DAT_W-1:0]   wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic [PIN_COUNT-1:0]  pin_i,
  input wire logic [PIN_COUNT-1:0]  pin_o,
  input wire logic [PIN_COUNT-1:0]  pin_oe_o,
  input wire logic [PIN_COUNT-1:0]  func_out_i,
  input wire logic [PIN_COUNT-1:0]  func_oe_i,
  input wire logic [PIN_COUNT-1:0]  func_in_o,
  input wire logic                  mux_mode_o
);
  logic [17:0] idx;
  logic        req;
  logic        unmapped;
  assign idx = wb_adr_i[19:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign unmapped = !((idx >= IDX_ENABLE_LOW && idx <= IDX_ENABLE_LOW + 18'h8) ||
                      idx == IDX_BUS_SELECT);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_next_cycle_a: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  read_upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  unmapped_read_a: assert property (req && !wb_we_i && unmapped |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  mode_write_a: assert property (req && wb_we_i && wb_sel_i[0] && idx == IDX_BUS_SELECT
    |=> mux_mode_o == $past(wb_dat_i[0]))
    else $error("mux mode not written");
  mux_enable_a: assert property ($past(mux_mode_o) |-> pin_oe_o == $past(func_oe_i))
    else $error("mux mode lost pin enables");
  mux_value_a: assert property ($past(mux_mode_o) |-> pin_o == $past(func_out_i))
    else $error("mux mode lost pin values");
  gp_hold_a: assert property (!$past(wb_ack_o) && !$past(mux_mode_o)
    |-> $stable(pin_oe_o) && $stable(pin_o))
    else $error("pin drive changed without a write");
  sync_delay_a: assert property (!$past(rst_i) && !$past(rst_i, 2)
    |-> func_in_o == $past(pin_i, 2))
    else $error("pin level not two cycles late");

  cover property (req && wb_we_i && idx == IDX_BUS_SELECT);
  cover property (mux_mode_o && |pin_oe_o);
  cover property (req && unmapped);
endmodule

bind shpg_port shpg_port_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i),
  .pin_o(pin_o), .pin_oe_o(pin_oe_o), .func_out_i(func_out_i), .func_oe_i(func_oe_i),
  .func_in_o(func_in_o), .mux_mode_o(mux_mode_o));

/* File: testbench.sv */
// Purpose: Self-checking bench for shpg_port
// Assumes: Answers within 50 cycles
// Notes:   Enable and direction are always written alike
`timescale 1ns/1ns
module testbench;
  import shpg_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [19:0] adr = 0;
  logic [3:0]  sel = 0;
  logic [31:0] wdat = 0;
  logic [31:0] rdat;
  logic        ack;
  logic        mode;
  logic [45:0] ext = 0;
  logic [45:0] lvl;
  logic [45:0] po;
  logic [45:0] poe;
  logic [45:0] fo = 0;
  logic [45:0] foe = 0;
  logic [45:0] fi;
  logic [47:0] m [3] = '{default: '0};
  logic [31:0] q;
  logic [31:0] r;
  logic [15:0] mk;
  int          seed = 32'hEA29;
  int          bad_count = 0;
  int          total_checks = 0;
  int          b;
  int          k;

  always #20 clk_i = ~clk_i;

  shpg_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_i(lvl), .pin_o(po), .pin_oe_o(poe), .func_out_i(fo), .func_oe_i(foe),
    .func_in_o(fi), .mux_mode_o(mode));
  shpg_pin_model far (.drv_i(po), .drv_oe_i(poe), .ext_i(ext), .level_o(lvl));

  task automatic tally_and_finish;
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Holds the request until ack is seen, then releases at that edge
  task automatic bus(input logic w, input int idx, input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx[17:0], 2'h0};
    sel <= s;
    wdat <= {16'($random(seed)), d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      tally_and_finish;
    end
  endtask

  task automatic wr(input int bk, input int kd, input logic [15:0] d, input logic [3:0] s);
    mk = {{8{s[1]}}, {8{s[0]}}} & (bk == 2 ? 16'h3FFF : 16'hFFFF);
    bus(1'b1, IDX_ENABLE_LOW + bk * 3 + kd, d, s);
    m[kd][bk*16 +: 16] = (m[kd][bk*16 +: 16] & ~mk) | (d & mk);
  endtask

  // Data reads give stored bits where driven, pin level elsewhere
  task automatic rd(input int bk, input int kd);
    logic [47:0] e;
    e = kd == 2 ? (m[1] & m[2]) | (~m[1] & {2'h0, lvl}) : m[kd];
    bus(1'b0, IDX_ENABLE_LOW + bk * 3 + kd, 16'h0000, 4'hF);
    check(q, e[bk*16 +: 16]);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    tally_and_finish;
  end

  initial begin
    ext <= 46'({$random(seed), $random(seed)});
    fo <= 46'({$random(seed), $random(seed)});
    foe <= 46'({$random(seed), $random(seed)});
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (b = 0; b < 3; b++) begin
      for (k = 0; k < 3; k++) rd(b, k);
    end
    for (int i = 0; i < 30; i++) begin
      b = i % 3;
      r = $random(seed);
      ext <= 46'({$random(seed), $random(seed)});
      wr(b, 0, r[15:0], 4'h3);
      wr(b, 1, r[15:0], 4'h3);
      wr(b, 2, r[31:16], 4'($random(seed)));
      for (k = 0; k < 3; k++) rd(b, k);
    end
    @(negedge clk_i);
    check(poe, m[0][45:0]);
    check(po, m[2][45:0]);
    bus(1'b1, 'h4409, 16'hFFFF, 4'hF);
    bus(1'b0, 'h4409, 16'h0000, 4'hF);
    check(q, 48'h0);
    rd(0, 0);
    bus(1'b1, IDX_BUS_SELECT, 16'h0001, 4'h1);
    repeat (2) @(negedge clk_i);
    check(mode, 48'h1);
    check(poe, foe);
    check(po, fo);
    repeat (2) @(negedge clk_i);
    check(fi, (foe & fo) | (~foe & ext));
    bus(1'b1, IDX_BUS_SELECT, 16'h0000, 4'h1);
    repeat (2) @(negedge clk_i);
    check(poe, m[0][45:0]);
    tally_and_finish;
  end
endmodule
